// ### rtl/adc_consts.svh
// How it works
// - power bit 1 runs the converter; 0 shuts it off, aborting any conversion.
// - port configuration bits 7 to 3 always read zero.
// - codes 000/010 five analog inputs; 001/011 four analog, fifth is reference.
// - completion loads result, clears start/done bit, sets complete flag.
// - reset leaves the result register untouched.
// - writing 1 to start/done while powered starts; bit reads 1 while busy.
// - channel select codes 000 to 100 pick channels 0 to 4.
// - a conversion lasts nine and a half conversion clock periods.
// - clock select 00 osc/2, 01 osc/8, 10 osc/32, 11 internal rc.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// ----------------------------------------
// register indices, byte address is index times four
// ----------------------------------------
`define ADC_IDX_RESULT 10'h01e
`define ADC_IDX_CTRL 10'h01f
`define ADC_IDX_PORTCFG 10'h09f
`define ADC_IDX_STATUS 10'h0a0
`define ADC_IDX_MASK 10'h0a1

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ADC_CTRL_ON 0
`define ADC_CTRL_GO 2
`define ADC_CTRL_CHAN_LO 3
`define ADC_CTRL_CLK_LO 6
`define ADC_CTRL_RESET 8'h00
`define ADC_PORTCFG_RESET 3'h0
`define ADC_FLAG_BIT 0

// ----------------------------------------
// timing
// ----------------------------------------
`define ADC_CLK_NS 4
`define ADC_RC_PERIOD_NS 4000
`define ADC_CONV_HALF_TICKS 19
`define ADC_HALF_OSC2 1
`define ADC_HALF_OSC8 4
`define ADC_HALF_OSC32 16

`endif

// ### rtl/adc_pkg.sv
package adc_pkg;
    typedef enum logic [1:0] {
        clk_osc2,
        clk_osc8,
        clk_osc32,
        clk_rc
    } conv_clk_t;

    typedef enum logic {
        sar_idle,
        sar_convert
    } sar_state_t;
endpackage : adc_pkg

// ### rtl/sar_engine.sv
`timescale 1ns/1ps
`include "adc_consts.svh"

module sar_engine #(
    parameter int HALF_W = 10
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic start,
    input wire logic [1:0] clk_sel,
    input wire logic comparator_in,
    output logic busy,
    output logic done,
    output logic [7:0] code
);
    localparam int RC_HALF = `ADC_RC_PERIOD_NS / `ADC_CLK_NS / 2;

    // refuse a divider too narrow for the rc half period
    if (RC_HALF < 1 || RC_HALF >= (1 << HALF_W) || HALF_W > 16) begin : g_half_check
        $error("sar_engine: HALF_W cannot hold the rc half period");
    end

    adc_pkg::sar_state_t state;
    logic [HALF_W-1:0] half_len;
    logic [HALF_W-1:0] div_cnt;
    logic [4:0] step;
    logic [2:0] cmp_sync;
    logic cmp_level;
    logic tick;
    logic [3:0] bit_idx;
    logic [HALF_W-1:0] next_half;

    assign busy = (state == adc_pkg::sar_convert);
    assign tick = busy && (div_cnt == half_len - HALF_W'(1));
    assign bit_idx = 4'(4'd8 - {1'b0, step[4:2], step[1]});

    // ----------------------------------------
    // comparator pin synchroniser
    // ----------------------------------------
    // level only moves when stages two and three agree
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmp_sync <= 3'h0;
            cmp_level <= 1'b0;
        end else begin
            cmp_sync <= {cmp_sync[1:0], comparator_in};
            if (cmp_sync[1] == cmp_sync[2]) begin
                cmp_level <= cmp_sync[2];
            end
        end
    end

    // half period of the selected conversion clock
    always_comb begin
        case (adc_pkg::conv_clk_t'(clk_sel))
            adc_pkg::clk_osc2: next_half = HALF_W'(`ADC_HALF_OSC2);
            adc_pkg::clk_osc8: next_half = HALF_W'(`ADC_HALF_OSC8);
            adc_pkg::clk_osc32: next_half = HALF_W'(`ADC_HALF_OSC32);
            default: next_half = HALF_W'(RC_HALF);
        endcase
    end

    // ----------------------------------------
    // conversion sequence
    // ----------------------------------------
    // clock select is latched so a mid-conversion write cannot warp timing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= adc_pkg::sar_idle;
            half_len <= HALF_W'(1);
            div_cnt <= '0;
            step <= 5'h0;
            done <= 1'b0;
            code <= 8'h00;
        end else begin
            done <= 1'b0;
            if (!enable) begin
                state <= adc_pkg::sar_idle;
                div_cnt <= '0;
            end else begin
                case (state)
                    adc_pkg::sar_idle: begin
                        if (start) begin
                            state <= adc_pkg::sar_convert;
                            half_len <= next_half;
                            div_cnt <= '0;
                            step <= 5'h0;
                            code <= 8'h80;
                        end
                    end
                    default: begin
                        div_cnt <= tick ? '0 : div_cnt + HALF_W'(1);
                        if (tick) begin
                            // 19 half periods make nine and a half periods
                            if (step == 5'(`ADC_CONV_HALF_TICKS - 1)) begin
                                state <= adc_pkg::sar_idle;
                                done <= 1'b1;
                            end else begin
                                step <= step + 5'h1;
                            end
                            if (!step[0] && step >= 5'd2 && step <= 5'd16) begin
                                code[bit_idx[2:0]] <= cmp_level;
                                if (bit_idx != 4'h0) begin
                                    code[bit_idx[2:0] - 3'h1] <= 1'b1;
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [15:0] busy_cycles;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cycles <= 16'h0000;
        end else if (start && !busy) begin
            busy_cycles <= 16'h0000;
        end else if (busy) begin
            busy_cycles <= busy_cycles + 16'h0001;
        end
    end

    conv_length_a: assert property (@(posedge clock) disable iff (!resetn)
        done |-> busy_cycles == 16'(19 * int'(half_len)))
        else $error("conversion length is not 9.5 conversion clock periods");

    clock_select_a: assert property (@(posedge clock) disable iff (!resetn)
        (enable && start && !busy && clk_sel == 2'b01) |=> half_len == HALF_W'(4))
        else $error("osc/8 does not give a half period of four cycles");
endmodule : sar_engine

// ### rtl/adc_control_sequencer.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "adc_consts.svh"

module adc_control_sequencer (
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_in,
    output logic converter_enable,
    output logic [2:0] channel_select,
    output logic sample_connect,
    output logic [7:0] dac_code,
    output logic [4:0] analog_pin_mask,
    output logic ref_external,
    output logic irq
);
    logic converter_power_on;
    logic go;
    logic [2:0] channel_select_field;
    logic [1:0] conversion_clock_select;
    logic [2:0] port_config_field;
    logic [7:0] conversion_result;
    logic conversion_complete_flag;
    logic conversion_irq_enable;
    logic eng_busy;
    logic eng_done;
    logic [7:0] eng_code;
    logic access;
    logic commit_wr;
    logic start;
    logic hit;
    logic [31:0] rd_word;
    logic [9:0] idx;

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign idx = paddr[11:2];
    assign access = psel && penable && !pready;
    assign commit_wr = psel && penable && pready && pwrite && !pslverr;

    // read mux, unmapped words answer with an error
    always_comb begin
        hit = 1'b1;
        rd_word = 32'h0000_0000;
        if (paddr[1:0] != 2'b00) begin
            hit = 1'b0;
        end else if (idx == `ADC_IDX_RESULT) begin
            rd_word[7:0] = conversion_result;
        end else if (idx == `ADC_IDX_CTRL) begin
            // bit 1 is unimplemented and reads zero
            rd_word[7:0] = {conversion_clock_select, channel_select_field, go, 1'b0,
                            converter_power_on};
        end else if (idx == `ADC_IDX_PORTCFG) begin
            rd_word[2:0] = port_config_field;
        end else if (idx == `ADC_IDX_STATUS) begin
            rd_word[`ADC_FLAG_BIT] = conversion_complete_flag;
        end else if (idx == `ADC_IDX_MASK) begin
            rd_word[`ADC_FLAG_BIT] = conversion_irq_enable;
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state: ready follows the first access cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && !hit;
            if (access && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    // ----------------------------------------
    // control register
    // ----------------------------------------
    // power state is sampled before the write, so a single write
    // that turns the module on and sets go does not start
    // the write must also keep power on, else a power-off write would pulse go
    assign start = commit_wr && idx == `ADC_IDX_CTRL && pwdata[`ADC_CTRL_GO]
        && pwdata[`ADC_CTRL_ON] && converter_power_on && !go;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            converter_power_on <= 1'b0;
            channel_select_field <= 3'h0;
            conversion_clock_select <= 2'h0;
        end else if (commit_wr && idx == `ADC_IDX_CTRL) begin
            converter_power_on <= pwdata[`ADC_CTRL_ON];
            channel_select_field <= pwdata[`ADC_CTRL_CHAN_LO +: 3];
            conversion_clock_select <= pwdata[`ADC_CTRL_CLK_LO +: 2];
        end
    end

    // go is owned by hardware once set; software clears it mid-run only by powering off
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            go <= 1'b0;
        end else if (!converter_power_on) begin
            go <= 1'b0;
        end else if (eng_done) begin
            go <= 1'b0;
        end else if (start) begin
            go <= 1'b1;
        end
    end

    // ----------------------------------------
    // result register, no reset by design
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (eng_done) begin
            conversion_result <= eng_code;
        end
    end

    // ----------------------------------------
    // port configuration and pin decode
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_config_field <= `ADC_PORTCFG_RESET;
        end else if (commit_wr && idx == `ADC_IDX_PORTCFG) begin
            port_config_field <= pwdata[2:0];
        end
    end

    // mask order is {ra5, ra3, ra2, ra1, ra0}
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            analog_pin_mask <= 5'h1f;
            ref_external <= 1'b0;
        end else begin
            case (port_config_field)
                3'b000, 3'b010: begin
                    analog_pin_mask <= 5'h1f;
                    ref_external <= 1'b0;
                end
                3'b001, 3'b011: begin
                    analog_pin_mask <= 5'h17;
                    ref_external <= 1'b1;
                end
                3'b100: begin
                    analog_pin_mask <= 5'h0b;
                    ref_external <= 1'b0;
                end
                3'b101: begin
                    analog_pin_mask <= 5'h03;
                    ref_external <= 1'b1;
                end
                default: begin
                    analog_pin_mask <= 5'h00;
                    ref_external <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    // a completion in the clearing cycle still sets the flag
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conversion_complete_flag <= 1'b0;
        end else if (eng_done) begin
            conversion_complete_flag <= 1'b1;
        end else if (commit_wr && idx == `ADC_IDX_STATUS && pwdata[`ADC_FLAG_BIT]) begin
            conversion_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conversion_irq_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (commit_wr && idx == `ADC_IDX_MASK) begin
                conversion_irq_enable <= pwdata[`ADC_FLAG_BIT];
            end
            irq <= conversion_complete_flag && conversion_irq_enable;
        end
    end

    // ----------------------------------------
    // pin facing outputs
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            converter_enable <= 1'b0;
            channel_select <= 3'h0;
            sample_connect <= 1'b0;
        end else begin
            converter_enable <= converter_power_on;
            channel_select <= channel_select_field;
            // holding cap leaves the pin while converting
            sample_connect <= converter_power_on && !eng_busy && !start;
        end
    end

    assign dac_code = eng_code;

    sar_engine #(
        .HALF_W(10)
    ) engine (
        .clock(clock),
        .resetn(resetn),
        .enable(converter_power_on),
        .start(start),
        .clk_sel(conversion_clock_select),
        .comparator_in(comparator_in),
        .busy(eng_busy),
        .done(eng_done),
        .code(eng_code)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    done_update_a: assert property (@(posedge clock) disable iff (!resetn)
        eng_done |=> (!go && conversion_complete_flag
        && conversion_result == $past(eng_code)))
        else $error("completion did not load result, clear go and set flag");

    same_edge_a: assert property (@(posedge clock) disable iff (!resetn)
        $fell(go) && converter_power_on |-> $rose(conversion_complete_flag)
        || conversion_complete_flag)
        else $error("go cleared without the flag on the same edge");

    power_off_a: assert property (@(posedge clock) disable iff (!resetn)
        !converter_power_on |=> !go && !eng_busy)
        else $error("converter still busy while powered off");

    start_busy_a: assert property (@(posedge clock) disable iff (!resetn)
        start |=> go && eng_busy)
        else $error("start write did not begin a conversion");

    cfg_upper_a: assert property (@(posedge clock) disable iff (!resetn)
        pready && !pwrite && idx == `ADC_IDX_PORTCFG |-> prdata[31:3] == 29'h0)
        else $error("port configuration upper bits read nonzero");

    pin_decode_a: assert property (@(posedge clock) disable iff (!resetn)
        !port_config_field[2] |=> analog_pin_mask == ($past(port_config_field[0]) ?
        5'h17 : 5'h1f) && ref_external == $past(port_config_field[0]))
        else $error("analog pin decode wrong for codes 000 to 011");

    channel_out_a: assert property (@(posedge clock) disable iff (!resetn)
        ##1 channel_select == $past(channel_select_field))
        else $error("channel select output does not follow the field");

    irq_level_a: assert property (@(posedge clock) disable iff (!resetn)
        conversion_complete_flag && conversion_irq_enable |=> irq)
        else $error("unmasked flag did not raise the interrupt");
endmodule : adc_control_sequencer

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "adc_consts.svh"

module tb_top;
    // ------------------------------------------------------------
    // clock, reset and design ports
    // ------------------------------------------------------------
    localparam logic [11:0] a_result = {`ADC_IDX_RESULT, 2'b00};
    localparam logic [11:0] a_ctrl = {`ADC_IDX_CTRL, 2'b00};
    localparam logic [11:0] a_portcfg = {`ADC_IDX_PORTCFG, 2'b00};
    localparam logic [11:0] a_status = {`ADC_IDX_STATUS, 2'b00};
    localparam logic [11:0] a_mask = {`ADC_IDX_MASK, 2'b00};
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic comparator_in = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, converter_enable, sample_connect, ref_external, irq;
    logic [2:0] channel_select;
    logic [7:0] dac_code;
    logic [7:0] analog_level = 8'h00;
    logic [4:0] analog_pin_mask;
    logic [4:0] pin_table [8] = '{5'h1f, 5'h17, 5'h1f, 5'h17, 5'h0b, 5'h03, 5'h00, 5'h00};
    logic ref_table [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    // osc/2 resolves faster than the pin filter settles, so it gets a steady level
    logic [7:0] level_table [4] = '{8'hff, 8'ha5, 8'h3c, 8'hff};
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    initial begin
        forever #2 clock = ~clock;
    end

    adc_control_sequencer dut (
        .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_in(comparator_in),
        .converter_enable(converter_enable), .channel_select(channel_select),
        .sample_connect(sample_connect), .dac_code(dac_code),
        .analog_pin_mask(analog_pin_mask), .ref_external(ref_external), .irq(irq)
    );

    // ideal comparator; the design's own filter adds the settling delay
    always @(posedge clock) begin
        comparator_in <= (analog_level >= dac_code);
    end

    // hang guard: the slowest conversion is some ten thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            $display("Error timeout expected 0 seen %0d", cycles);
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // compare, bus and sequence tasks
    // ------------------------------------------------------------
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic check_count(input string name, input int exp, input int got);
        comparisons++;
        if (got != exp) begin
            n_errors++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_count

    // one apb transfer; pready is read before this edge's updates land
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clock);
        penable <= 1'b1;
        forever begin
            @(posedge clock);
            if (pready === 1'b1 || n > 50) break;
            n++;
        end
        if (n > 50) check_count("pready wait", 0, n);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [11:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, data, rd, err);
        check_val("write error", 32'h0000_0000, {31'h0, err});
    endtask : wr_reg

    task automatic rd_check(input string name, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0000_0000, rd, err);
        check_val(name, exp, rd);
        check_val("read error", 32'h0000_0000, {31'h0, err});
    endtask : rd_check

    task automatic convert(input int sel, input logic [7:0] level, input logic irq_on);
        int half;
        int n;
        logic [31:0] w;
        half = (sel == 0) ? 1 : (sel == 1) ? 4 : (sel == 2) ? 16 : 500;
        w = (32'(sel) << 6) | (32'(sel) << 3) | 32'h0000_0001;
        analog_level <= level;
        wr_reg(a_ctrl, w);
        wr_reg(a_status, 32'h0000_0001);
        repeat (20) @(posedge clock);
        wr_reg(a_ctrl, w | 32'h0000_0004);
        n = 0;
        while (sample_connect !== 1'b0 && n < 100) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        // sample_connect is registered, so it rises one edge after busy ends
        while (sample_connect === 1'b0 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        check_count("conversion cycles", 19 * half + 1, n);
        rd_check("ctrl after done", a_ctrl, w);
        rd_check("result", a_result, {24'h0, level});
        rd_check("flag after done", a_status, 32'h0000_0001);
        check_val("irq level", {31'h0, irq_on}, {31'h0, irq});
        wr_reg(a_status, 32'h0000_0001);
        rd_check("flag cleared", a_status, 32'h0000_0000);
        check_val("irq cleared", 32'h0000_0000, {31'h0, irq});
        repeat (4 * half) @(posedge clock);
    endtask : convert

    task automatic finish_test();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic err;
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        check_val("pins at reset", 32'h0000_001f, {27'h0, analog_pin_mask});
        rd_check("ctrl reset", a_ctrl, {24'h0, `ADC_CTRL_RESET});
        rd_check("portcfg reset", a_portcfg, 32'h0000_0000);
        rd_check("mask reset", a_mask, 32'h0000_0000);
        // unmapped and misaligned places are refused with an error
        apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
        check_val("unmapped err", 32'h0000_0001, {31'h0, err});
        apb(1'b1, 12'h27d, 32'h0000_0006, rd, err);
        check_val("misaligned err", 32'h0000_0001, {31'h0, err});
        rd_check("portcfg kept", a_portcfg, 32'h0000_0000);
        // every port code, upper bits written as ones
        for (int c = 0; c < 8; c++) begin
            wr_reg(a_portcfg, 32'h0000_00f8 | 32'(c));
            rd_check("portcfg read", a_portcfg, 32'(c));
            check_val("pin mask", 32'(pin_table[c]), 32'(analog_pin_mask));
            check_val("ref pin", 32'(ref_table[c]), 32'(ref_external));
        end
        // start in the powering write, or while off, is ignored
        wr_reg(a_ctrl, 32'h0000_0005);
        rd_check("go with power on", a_ctrl, 32'h0000_0001);
        check_val("enable on", 32'h0000_0001, 32'(converter_enable));
        wr_reg(a_ctrl, 32'h0000_0004);
        rd_check("go while off", a_ctrl, 32'h0000_0000);
        check_val("enable off", 32'h0000_0000, 32'(converter_enable));
        for (int ch = 0; ch < 5; ch++) begin
            wr_reg(a_ctrl, (32'(ch) << 3) | 32'h0000_0001);
            // field lands at the commit edge, the pin one edge later
            repeat (2) @(posedge clock);
            check_val("channel", 32'(ch), 32'(channel_select));
        end
        // first conversion unmasked off, then irq enabled
        for (int s = 0; s < 4; s++) begin
            if (s == 1) wr_reg(a_mask, 32'h0000_0001);
            convert(s, level_table[s], s > 0);
        end
        // a second reset leaves the result alone
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        rd_check("result after reset", a_result, 32'h0000_00ff);
        rd_check("ctrl after reset", a_ctrl, {24'h0, `ADC_CTRL_RESET});
        // power off mid conversion aborts without a flag
        analog_level <= 8'h11;
        wr_reg(a_ctrl, 32'h0000_00c1);
        wr_reg(a_ctrl, 32'h0000_00c5);
        rd_check("go while busy", a_ctrl, 32'h0000_00c5);
        repeat (50) @(posedge clock);
        wr_reg(a_ctrl, 32'h0000_00c0);
        rd_check("ctrl after abort", a_ctrl, 32'h0000_00c0);
        rd_check("no flag on abort", a_status, 32'h0000_0000);
        rd_check("result kept", a_result, 32'h0000_00ff);
        check_val("enable after abort", 32'h0000_0000, 32'(converter_enable));
        finish_test();
    end
endmodule : tb_top
